//--- design/break_pulse_gen.v
// Break pulse generator: holds the transmit line low for a coded length.
// Assumes start is a one-cycle pulse with a code of 1 to 6.
`timescale 1ns/1ps
`include "config_set_consts.vh"

module break_pulse_gen #(
	parameter TICK_CYCLES = `BREAK_TICK_CYCLES
) (
	input wire clk,
	input wire reset,
	input wire start,
	input wire [2:0] code,
	output reg active
);

function [6:0] break_ticks;
	input [2:0] c;
	begin
		case (c)
			3'h1: break_ticks = `BREAK_TICKS_1;
			3'h2: break_ticks = `BREAK_TICKS_2;
			3'h3: break_ticks = `BREAK_TICKS_3;
			3'h4: break_ticks = `BREAK_TICKS_4;
			3'h5: break_ticks = `BREAK_TICKS_5;
			3'h6: break_ticks = `BREAK_TICKS_6;
			default: break_ticks = 7'h00;
		endcase
	end
endfunction

reg [19:0] div;
reg [6:0] remaining;
wire tick = (div == TICK_CYCLES - 1);

////////////////////////////////////////////////////////////////////////////////
// Divider restarts with each break so the length is exact to the cycle
always @(posedge clk or posedge reset) begin
	if (reset) begin
		div <= 20'h00000;
		remaining <= 7'h00;
		active <= 1'b0;
	end else if (start) begin
		div <= 20'h00000;
		remaining <= break_ticks(code); // R06
		active <= (break_ticks(code) != 7'h00); // R06
	end else if (remaining != 7'h00) begin
		if (tick) begin
			div <= 20'h00000;
			remaining <= remaining - 7'h01;
			active <= (remaining != 7'h01);
		end else begin
			div <= div + 20'h00001;
		end
	end
end

endmodule // break_pulse_gen

//--- design/config_set_command_parser.v
// Configuration set command parser with APB register access.
// Assumes received characters arrive one per RX_VALID cycle from a UART.
// Behaviour
// R01 - Settings stored, applied only at reboot
// R02 - Seven-bit flag: 0 off, 1 on
// R03 - Auth policy values 0, 1, 2, 4
// R04 - Always answer peer pin demand
// R05 - Keep eight link keys, oldest replaced
// R06 - Break holds transmit low, coded length
// R07 - Service command writes class upper word
// R08 - Device command writes class lower word
// R09 - New firmware: command sets outbound UUID
// R10 - Short hex overwrites leading UUID digits
// R11 - Letters S, I, C load presets
// R12 - New firmware always encrypts link
// R13 - Old firmware: flag sets encryption
// R14 - Keywords any case, comma arguments, decimal
// R15 - Host ends each line with return
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "config_set_consts.vh"

module config_set_command_parser #(
	parameter HALF_MS_CYCLES = `BREAK_TICK_CYCLES
) (
	input wire CORE_CLK,
	input wire RESET,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg PREADY,
	output reg [31:0] PRDATA,
	output reg PSLVERR,
	input wire RX_VALID,
	input wire [7:0] RX_CHAR,
	output wire UART_TX_FORCE_LOW,
	input wire PIN_REQUEST,
	output reg PIN_REPLY,
	input wire KEY_STORE,
	input wire [127:0] KEY_IN,
	output reg SEVEN_BIT_MODE,
	output reg [2:0] AUTH_POLICY,
	output reg LINK_ENCRYPT,
	output reg [23:0] CLASS_OF_DEVICE,
	output reg [151:0] OUTBOUND_UUID
);

localparam P_IDLE = 3'h0;
localparam P_KEY = 3'h1;
localparam P_COMMA = 3'h2;
localparam P_ARG = 3'h3;
localparam P_SKIP = 3'h4;
localparam [15:0] DEF_UPPER = `DEF_UPPER_WORD;

function [7:0] upcase;
	input [7:0] c;
	begin
		upcase = (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
	end
endfunction

// Valid flag above a nibble value
function [4:0] hex_nib;
	input [7:0] c;
	reg [7:0] u;
	begin
		u = upcase(c);
		if (u >= 8'h30 && u <= 8'h39)
			hex_nib = {1'b1, u[3:0]};
		else if (u >= `CH_A && u <= 8'h46)
			hex_nib = {1'b1, u[3:0] + 4'h9};
		else
			hex_nib = 5'h00;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// State

reg [2:0] pstate;
reg [7:0] cmd_key;
reg [5:0] arg_len;
reg [7:0] first_char;
reg [9:0] dec_acc;
reg dec_bad;
reg [15:0] hex_acc;
reg hex_bad;
reg [151:0] uuid_work;
reg st_seven;
reg [2:0] st_auth;
reg st_encrypt;
reg [15:0] st_upper;
reg [15:0] st_lower;
reg [151:0] st_uuid;
reg act_encrypt;
reg new_fw;
reg last_ok;
reg last_err;
reg break_start;
reg [2:0] break_code;
reg [2:0] uuid_sel;
reg [4:0] key_sel;
reg [127:0] key_mem [0:7];
reg [2:0] key_wr_ptr;
reg [3:0] key_count;
reg next_ok;
reg shortcut;
reg [151:0] preset;
reg mapped;
reg [31:0] rd_data;
reg [127:0] sel_key;

wire [7:0] uc = upcase(RX_CHAR);
wire [4:0] hn = hex_nib(RX_CHAR);
wire is_digit = (RX_CHAR >= 8'h30 && RX_CHAR <= 8'h39);
wire dec_ok = (arg_len != 6'h00) && !dec_bad;
wire apb_write = PSEL & PENABLE & PWRITE & PREADY;
wire reboot = apb_write && (PADDR == `REG_CTRL) && PWDATA[`CTRL_REBOOT_BIT];

////////////////////////////////////////////////////////////////////////////////
// Line evaluation at carriage return

always @* begin
	next_ok = 1'b0;
	shortcut = (arg_len == 6'h01) &&
		(first_char == `CH_S || first_char == `CH_I || first_char == `CH_C); // R11
	case (first_char)
		`CH_I: preset = `UUID_PRESET_I; // R11
		`CH_C: preset = `UUID_PRESET_C; // R11
		default: preset = `UUID_DEFAULT; // R11
	endcase
	case (cmd_key)
		`CH_7: next_ok = dec_ok && dec_acc <= 10'h001; // R02
		`CH_A: next_ok = dec_ok && (dec_acc <= 10'h002 || dec_acc == 10'h004); // R03
		`CH_B: next_ok = dec_ok && dec_acc >= 10'h001 && dec_acc <= 10'h006; // R06
		`CH_C, `CH_D: next_ok = arg_len != 6'h00 && arg_len <= 6'h04 && !hex_bad;
		`CH_E: begin
			if (new_fw)
				next_ok = shortcut || (arg_len != 6'h00 && !hex_bad); // R09
			else
				next_ok = dec_ok && dec_acc <= 10'h001; // R13
		end
		default: next_ok = 1'b0;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Character parser and stored settings

always @(posedge CORE_CLK or posedge RESET) begin
	if (RESET) begin
		pstate <= P_IDLE;
		cmd_key <= 8'h00;
		arg_len <= 6'h00;
		first_char <= 8'h00;
		dec_acc <= 10'h000;
		dec_bad <= 1'b0;
		hex_acc <= 16'h0000;
		hex_bad <= 1'b0;
		uuid_work <= `UUID_DEFAULT;
		st_seven <= `DEF_SEVEN;
		st_auth <= `DEF_AUTH;
		st_encrypt <= `DEF_ENCRYPT;
		st_upper <= `DEF_UPPER_WORD;
		st_lower <= `DEF_LOWER_WORD;
		st_uuid <= `UUID_DEFAULT;
		last_ok <= 1'b0;
		last_err <= 1'b0;
		break_start <= 1'b0;
		break_code <= 3'h0;
	end else begin
		break_start <= 1'b0;
		if (RX_VALID) begin
			if (RX_CHAR == `CH_CR) begin
				// Only a completed line is acted on
				pstate <= P_IDLE; // R15
				if (pstate == P_ARG && next_ok) begin
					last_ok <= 1'b1;
					case (cmd_key)
						`CH_7: st_seven <= dec_acc[0]; // R02
						`CH_A: st_auth <= dec_acc[2:0]; // R03
						`CH_B: begin
							break_start <= 1'b1; // R06
							break_code <= dec_acc[2:0];
						end
						`CH_C: st_upper <= hex_acc; // R07
						`CH_D: st_lower <= hex_acc; // R08
						`CH_E: begin
							if (!new_fw)
								st_encrypt <= dec_acc[0]; // R13
							else if (shortcut)
								st_uuid <= preset; // R11
							else
								st_uuid <= uuid_work; // R10
						end
						default: last_ok <= 1'b1;
					endcase
				end else if (pstate != P_IDLE) begin
					last_err <= 1'b1;
				end
			end else if (RX_CHAR != `CH_LF) begin
				case (pstate)
					P_IDLE: begin
						last_ok <= 1'b0;
						last_err <= 1'b0;
						pstate <= (uc == `CH_S) ? P_KEY : P_SKIP; // R14
					end
					P_KEY: begin
						if (uc == `CH_7 || (uc >= `CH_A && uc <= `CH_E)) begin
							cmd_key <= uc; // R14
							pstate <= P_COMMA;
						end else begin
							pstate <= P_SKIP;
						end
					end
					P_COMMA: begin
						arg_len <= 6'h00;
						dec_acc <= 10'h000;
						dec_bad <= 1'b0;
						hex_acc <= 16'h0000;
						hex_bad <= 1'b0;
						uuid_work <= st_uuid; // R10
						pstate <= (RX_CHAR == `CH_COMMA) ? P_ARG : P_SKIP; // R14
					end
					P_ARG: begin
						if (!(RX_CHAR == `CH_SPACE && arg_len == 6'h00)) begin
							if (arg_len == 6'h00)
								first_char <= uc;
							if (arg_len != 6'h3f)
								arg_len <= arg_len + 6'h01;
							// Three digits cover every decimal value used here
							if (is_digit && arg_len < 6'h03)
								dec_acc <= dec_acc * 10'd10 + {6'h00, RX_CHAR[3:0]}; // R14
							else
								dec_bad <= 1'b1;
							if (!hn[4])
								hex_bad <= 1'b1;
							hex_acc <= {hex_acc[11:0], hn[3:0]};
							if (cmd_key == `CH_E && arg_len >= `UUID_NIBBLES)
								hex_bad <= 1'b1;
							else if (cmd_key == `CH_E && hn[4])
								uuid_work[151 - 4 * arg_len -: 4] <= hn[3:0]; // R10
						end
					end
					P_SKIP: pstate <= P_SKIP;
					default: pstate <= P_IDLE;
				endcase
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Active settings, loaded only on reboot; link encryption and pin reply follow their inputs every cycle

always @(posedge CORE_CLK or posedge RESET) begin
	if (RESET) begin
		SEVEN_BIT_MODE <= `DEF_SEVEN;
		AUTH_POLICY <= `DEF_AUTH;
		act_encrypt <= `DEF_ENCRYPT;
		CLASS_OF_DEVICE <= {DEF_UPPER[7:0], `DEF_LOWER_WORD};
		OUTBOUND_UUID <= `UUID_DEFAULT;
		LINK_ENCRYPT <= 1'b0;
		PIN_REPLY <= 1'b0;
	end else begin
		if (reboot) begin
			SEVEN_BIT_MODE <= st_seven; // R01
			AUTH_POLICY <= st_auth; // R01
			act_encrypt <= st_encrypt; // R01
			CLASS_OF_DEVICE <= {st_upper[7:0], st_lower}; // R07 R08
			OUTBOUND_UUID <= st_uuid; // R09
		end
		LINK_ENCRYPT <= new_fw | act_encrypt; // R12 R13
		PIN_REPLY <= PIN_REQUEST; // R04
	end
end

////////////////////////////////////////////////////////////////////////////////
// Link key store, oldest slot reused once full

always @(posedge CORE_CLK) begin
	if (KEY_STORE)
		key_mem[key_wr_ptr] <= KEY_IN; // R05
end

always @(posedge CORE_CLK or posedge RESET) begin
	if (RESET) begin
		key_wr_ptr <= 3'h0;
		key_count <= 4'h0;
	end else if (KEY_STORE) begin
		key_wr_ptr <= key_wr_ptr + 3'h1; // R05
		if (key_count != `KEY_SLOTS)
			key_count <= key_count + 4'h1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// APB read decode

always @* begin
	mapped = 1'b1;
	rd_data = 32'h00000000;
	sel_key = key_mem[key_sel[4:2]];
	case (PADDR)
		`REG_CTRL: rd_data = {31'h00000000, new_fw};
		`REG_STATUS: rd_data = {24'h000000, key_count, pstate != P_IDLE,
			UART_TX_FORCE_LOW, last_err, last_ok};
		`REG_STORED_CFG: rd_data = {27'h0000000, st_encrypt, st_auth, st_seven};
		`REG_ACTIVE_CFG: rd_data = {27'h0000000, act_encrypt, AUTH_POLICY, SEVEN_BIT_MODE};
		`REG_COD_WORDS: rd_data = {st_upper, st_lower};
		`REG_COD_ACTIVE: rd_data = {8'h00, CLASS_OF_DEVICE};
		`REG_UUID_SEL: rd_data = {29'h00000000, uuid_sel};
		`REG_UUID_DATA: begin
			case (uuid_sel)
				3'h0: rd_data = {8'h00, st_uuid[151:128]};
				3'h1: rd_data = st_uuid[127:96];
				3'h2: rd_data = st_uuid[95:64];
				3'h3: rd_data = st_uuid[63:32];
				3'h4: rd_data = st_uuid[31:0];
				default: rd_data = 32'h00000000;
			endcase
		end
		`REG_KEY_SEL: rd_data = {27'h0000000, key_sel};
		`REG_KEY_DATA: begin
			case (key_sel[1:0])
				2'h0: rd_data = sel_key[127:96];
				2'h1: rd_data = sel_key[95:64];
				2'h2: rd_data = sel_key[63:32];
				default: rd_data = sel_key[31:0];
			endcase
		end
		default: mapped = 1'b0;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// APB slave, one wait state

always @(posedge CORE_CLK or posedge RESET) begin
	if (RESET) begin
		PREADY <= 1'b0;
		PRDATA <= 32'h00000000;
		PSLVERR <= 1'b0;
		new_fw <= `CTRL_NEWFW_RESET;
		uuid_sel <= 3'h0;
		key_sel <= 5'h00;
	end else if (PSEL && PENABLE && !PREADY) begin
		PREADY <= 1'b1;
		PSLVERR <= !mapped;
		PRDATA <= PWRITE ? 32'h00000000 : rd_data;
	end else begin
		PREADY <= 1'b0;
		PSLVERR <= 1'b0;
		if (apb_write) begin
			case (PADDR)
				`REG_CTRL: new_fw <= PWDATA[`CTRL_NEWFW_BIT];
				`REG_UUID_SEL: uuid_sel <= PWDATA[2:0];
				`REG_KEY_SEL: key_sel <= PWDATA[4:0];
				default: new_fw <= new_fw;
			endcase
		end
	end
end

break_pulse_gen #(
	.TICK_CYCLES(HALF_MS_CYCLES)
) u_break (
	.clk(CORE_CLK),
	.reset(RESET),
	.start(break_start),
	.code(break_code),
	.active(UART_TX_FORCE_LOW)
);

endmodule // config_set_command_parser

//--- include/config_set_consts.vh
// Constants of the configuration set command parser.
// Included by the parser and its break pulse generator; definitions only.
`ifndef CONFIG_SET_CONSTS_VH
`define CONFIG_SET_CONSTS_VH

// Timing
`define CLK_MHZ 100
`define BREAK_TICK_US 500
`define BREAK_TICK_CYCLES (`BREAK_TICK_US * `CLK_MHZ)
// Break lengths in half-millisecond ticks: 37, 18.5, 12, 9, 7, 6 ms
`define BREAK_TICKS_1 7'd74
`define BREAK_TICKS_2 7'd37
`define BREAK_TICKS_3 7'd24
`define BREAK_TICKS_4 7'd18
`define BREAK_TICKS_5 7'd14
`define BREAK_TICKS_6 7'd12

// APB byte addresses
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_STORED_CFG 8'h08
`define REG_ACTIVE_CFG 8'h0c
`define REG_COD_WORDS 8'h10
`define REG_COD_ACTIVE 8'h14
`define REG_UUID_SEL 8'h18
`define REG_UUID_DATA 8'h1c
`define REG_KEY_SEL 8'h20
`define REG_KEY_DATA 8'h24

// Control fields
`define CTRL_NEWFW_BIT 0
`define CTRL_REBOOT_BIT 1
`define CTRL_NEWFW_RESET 1'b1

// Authentication policies
`define AUTH_OPEN 3'h0
`define AUTH_SSP_CONFIRM 3'h1
`define AUTH_SSP_NOCONFIRM 3'h2
`define AUTH_PIN 3'h4

// Setting defaults
`define DEF_SEVEN 1'b0
`define DEF_AUTH `AUTH_SSP_CONFIRM
`define DEF_ENCRYPT 1'b0
`define DEF_UPPER_WORD 16'h0000
`define DEF_LOWER_WORD 16'h1f00
`define UUID_DEFAULT 152'h35111c0000110100001000800000805f9b34fb
`define UUID_PRESET_I 152'h35111c00000000decafadedecadeafdecacafe
`define UUID_PRESET_C 152'h35111cee286ea0000111e1be500800200c9a66
`define UUID_NIBBLES 6'd38

// Link key store
`define KEY_SLOTS 4'h8

// Characters
`define CH_CR 8'h0d
`define CH_LF 8'h0a
`define CH_SPACE 8'h20
`define CH_COMMA 8'h2c
`define CH_S 8'h53
`define CH_I 8'h49
`define CH_C 8'h43
`define CH_7 8'h37
`define CH_A 8'h41
`define CH_B 8'h42
`define CH_D 8'h44
`define CH_E 8'h45

`endif

//--- verification/config_set_asserts.sv
// Port checker for the set command parser.
// Assumes HALF_MS_CYCLES matches the bound design instance.
`timescale 1ns/1ps
`include "config_set_consts.vh"
module config_set_asserts #(
	parameter HALF_MS_CYCLES = 50000
) (
	input wire CORE_CLK,
	input wire RESET,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	input wire PREADY,
	input wire [31:0] PRDATA,
	input wire PSLVERR,
	input wire RX_VALID,
	input wire [7:0] RX_CHAR,
	input wire UART_TX_FORCE_LOW,
	input wire PIN_REQUEST,
	input wire PIN_REPLY,
	input wire SEVEN_BIT_MODE,
	input wire [2:0] AUTH_POLICY,
	input wire [23:0] CLASS_OF_DEVICE,
	input wire [151:0] OUTBOUND_UUID
);
	localparam int MAXLEN = 74 * HALF_MS_CYCLES + 1;
	localparam int MINLEN = 12 * HALF_MS_CYCLES - 1;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	logic [31:0] cnt;
	wire reboot = PSEL && PENABLE && PREADY && PWRITE && PADDR == `REG_CTRL && PWDATA[1];
	wire cr_in = RX_VALID && RX_CHAR == `CH_CR;
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			cnt <= 32'h0;
		else if (UART_TX_FORCE_LOW)
			cnt <= cnt + 32'h1;
		else
			cnt <= 32'h0;
	end
	////////////////////////////////////////////////////////////////
	pin_answer_a: assert property (PIN_REQUEST |=> PIN_REPLY)
		else $error("pin demand not answered");
	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	one_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("access not answered after one wait");
	err_ready_a: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	rdata_hold_a: assert property ($changed(PRDATA) |-> PREADY)
		else $error("read data moved outside an answer");
	settings_hold_a: assert property ($changed({SEVEN_BIT_MODE, AUTH_POLICY,
		CLASS_OF_DEVICE, OUTBOUND_UUID}) |-> $past(reboot) || $past(reboot, 2))
		else $error("active setting changed without reboot");
	break_start_a: assert property ($rose(UART_TX_FORCE_LOW) |->
		$past(cr_in, 2) || $past(cr_in, 3))
		else $error("break not started by a line end");
	break_max_a: assert property (UART_TX_FORCE_LOW |-> cnt <= MAXLEN)
		else $error("break too long");
	break_min_a: assert property ($fell(UART_TX_FORCE_LOW) |-> $past(cnt) >= MINLEN)
		else $error("break too short");
	cover property ($fell(UART_TX_FORCE_LOW));
	cover property (PSLVERR);
	cover property (reboot);
endmodule // config_set_asserts
bind config_set_command_parser config_set_asserts #(.HALF_MS_CYCLES(HALF_MS_CYCLES)) u_chk (
	.CORE_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PRDATA,
	.PSLVERR, .RX_VALID, .RX_CHAR, .UART_TX_FORCE_LOW, .PIN_REQUEST, .PIN_REPLY,
	.SEVEN_BIT_MODE, .AUTH_POLICY, .CLASS_OF_DEVICE, .OUTBOUND_UUID);

//--- verification/config_set_command_parser_bench.sv
// Self-checking bench for the set command parser.
// Assumes a host model on the character input and APB from this module.
`timescale 1ns/1ps
`include "config_set_consts.vh"
module config_set_command_parser_bench;
	localparam HALF = 10;
	logic CORE_CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA;
	logic PIN_REQUEST = 1'b0, KEY_STORE = 1'b0;
	logic u_ctrl_fw = 1'b1;
	logic [127:0] KEY_IN = 128'h0;
	wire PREADY, PSLVERR, UART_TX_FORCE_LOW, PIN_REPLY, SEVEN_BIT_MODE, LINK_ENCRYPT;
	wire rx_valid;
	wire [7:0] rx_data;
	wire [2:0] AUTH_POLICY;
	wire [23:0] CLASS_OF_DEVICE;
	wire [151:0] OUTBOUND_UUID;
	logic [32:0] exp_q[$], msk_q[$], m;
	int n_mismatch = 0, check_count = 0, n, len, t, code;
	logic [15:0] v;
	string s;
	int av[5] = '{0, 1, 2, 4, 3};
	string sl[3] = '{"S", "I", "C"};
	logic [31:0] sw[3] = '{32'h5f9b34fb, 32'hdecafade, 32'hee286ea0};
	int si[3] = '{4, 2, 1};
	int ticks[6] = '{74, 37, 24, 18, 14, 12};
	always #5 CORE_CLK = ~CORE_CLK;
	config_set_command_parser #(.HALF_MS_CYCLES(HALF)) u_dut (.CORE_CLK, .RESET, .PSEL,
		.PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PRDATA, .PSLVERR,
		.RX_VALID(rx_valid), .RX_CHAR(rx_data), .UART_TX_FORCE_LOW, .PIN_REQUEST,
		.PIN_REPLY, .KEY_STORE, .KEY_IN, .SEVEN_BIT_MODE, .AUTH_POLICY, .LINK_ENCRYPT,
		.CLASS_OF_DEVICE, .OUTBOUND_UUID);
	host_uart_model u_host (.clk(CORE_CLK), .valid(rx_valid), .data(rx_data));
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [32:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic stop_hung;
		n_mismatch++;
		report_and_stop();
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e, mk);
		exp_q.push_back(e & mk);
		msk_q.push_back(mk);
		@(posedge CORE_CLK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		for (n = 0; n < 50 && PREADY !== 1'b1; n++)
			@(posedge CORE_CLK);
		if (n == 50)
			stop_hung();
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, mk = 32'hffffffff);
		apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, mk});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0, 33'h100000000);
	endtask
	task automatic reboot;
		wr(`REG_CTRL, {30'h0, 1'b1, u_ctrl_fw});
		repeat (2) @(posedge CORE_CLK);
	endtask
	always @(posedge CORE_CLK)
		if (PREADY === 1'b1) begin
			if (exp_q.size() == 0)
				check("unexpected answer", 33'h1, 33'h0);
			else begin
				m = msk_q.pop_front();
				check("apb answer", {PSLVERR, PRDATA} & m, exp_q.pop_front());
			end
		end
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h94dc5904));
		repeat (4) @(posedge CORE_CLK);
		RESET <= 1'b0;
		wr(`REG_UUID_SEL, 32'h0);
		rd(`REG_STORED_CFG, 32'h2);
		rd(`REG_COD_WORDS, 32'h1f00);
		rd(`REG_UUID_DATA, 32'h0035111c);
		$display("done: defaults");
		v = $urandom;
		s = $sformatf("sc,%h", v);
		u_host.send("s7,1");
		u_host.send("SA,4");
		u_host.send(s.toupper());
		u_host.send("SD,0123");
		u_host.send("SE,ABCD");
		rd(`REG_STORED_CFG, 32'h9, 32'h1f);
		rd(`REG_COD_WORDS, {v, 16'h0123});
		rd(`REG_UUID_DATA, 32'h00abcd1c);
		check("cod", CLASS_OF_DEVICE, 24'h001f00);
		reboot();
		check("cod", CLASS_OF_DEVICE, {v[7:0], 16'h0123});
		check("auth", AUTH_POLICY, 3'h4);
		check("seven", SEVEN_BIT_MODE, 1'b1);
		check("uuid", OUTBOUND_UUID[151:128], 24'habcd1c);
		check("encrypt", LINK_ENCRYPT, 1'b1);
		$display("done: store and reboot");
		foreach (av[i]) begin
			u_host.send($sformatf("sa,%0d", av[i]));
			rd(`REG_STATUS, av[i] == 3 ? 32'h2 : 32'h1, 32'h3);
		end
		rd(`REG_STORED_CFG, 32'h8, 32'he);
		PIN_REQUEST <= 1'b1;
		@(posedge CORE_CLK);
		PIN_REQUEST <= 1'b0;
		@(posedge CORE_CLK);
		check("pin", PIN_REPLY, 1'b1);
		foreach (sl[i]) begin
			u_host.send({"SE,", sl[i]});
			wr(`REG_UUID_SEL, si[i]);
			rd(`REG_UUID_DATA, sw[i]);
		end
		$display("done: policies and shortcuts");
		u_ctrl_fw = 1'b0;
		// Old command meaning must be in force before the lines are sent
		wr(`REG_CTRL, 32'h0);
		for (int f = 1; f >= 0; f--) begin
			u_host.send($sformatf("SE,%0d", f));
			rd(`REG_STORED_CFG, f << 4, 32'h10);
			reboot();
			check("encrypt", LINK_ENCRYPT, f[0]);
		end
		u_ctrl_fw = 1'b1;
		reboot();
		code = 1 + $urandom % 6;
		t = ticks[code - 1] * HALF;
		u_host.send($sformatf("SB,%0d", code));
		for (n = 0; n < 20 && UART_TX_FORCE_LOW !== 1'b1; n++)
			@(posedge CORE_CLK);
		for (len = 0; len < 2000 && UART_TX_FORCE_LOW === 1'b1; len++)
			@(posedge CORE_CLK);
		check("break", len >= t - 1 && len <= t + 1, 1'b1);
		$display("done: break");
		for (int k = 0; k < 9; k++) begin
			@(posedge CORE_CLK);
			KEY_STORE <= 1'b1;
			KEY_IN <= {$urandom, $urandom, $urandom, $urandom};
		end
		@(posedge CORE_CLK);
		KEY_STORE <= 1'b0;
		rd(`REG_STATUS, 32'h80, 32'hf0);
		wr(`REG_KEY_SEL, 32'h3);
		rd(`REG_KEY_DATA, KEY_IN[31:0]);
		apb(1'b0, 8'h40, 32'h0, 33'h100000000, 33'h1ffffffff);
		apb(1'b1, 8'h44, 32'h1, 33'h100000000, 33'h1ffffffff);
		$display("done: keys and unmapped");
		report_and_stop();
	end
endmodule // config_set_command_parser_bench

//--- verification/host_uart_model.sv
// Host terminal model: sends command lines, one character a cycle.
// Assumes the parser takes every character with no back-pressure.
`timescale 1ns/1ps
module host_uart_model (
	input wire clk,
	output logic valid,
	output logic [7:0] data
);
	initial begin
		valid = 1'b0;
		data = 8'h00;
	end
	////////////////////////////////////////////////////////////////
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge clk);
			valid <= 1'b1;
			data <= s[i];
		end
		@(posedge clk);
		data <= 8'h0d;
		@(posedge clk);
		valid <= 1'b0;
		// Idle line shows no stale character
		data <= 8'hf2;
	endtask
endmodule // host_uart_model
